// ===== host_model.sv
// Purpose: Host side of the register bank
// Assumes: Decoded byte strobes, three-emitter part
// Notes:   Data bus shows inverse of d outside transfer cycles
module host_model (
  input  wire logic       mclk_i,
  output logic            wr_en_o = 1'b0,
  output logic            rd_en_o = 1'b0,
  output logic [7:0]      addr_o = 8'h00,
  output logic [7:0]      wdata_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // Called only while no result strobe is pending
  // Limits are only rewritten while measurements are halted
  // Three-emitter part, so emitter two and three codes may be nonzero
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_en_o <= w;
    rd_en_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_en_o <= 1'b0;
    rd_en_o <= 1'b0;
    wdata_o <= ~d;
  endtask
endmodule // host_model

// ===== tb_threshold_led_drive_regs.sv
// Purpose: Self-checking bench for the limit and drive bank
// Assumes: Current silicon, then a legacy-silicon pass, three-emitter part
// Notes:   Host traffic comes from host_model
module tb_threshold_led_drive_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, rst_n_i = 0, legacy_rev_i = 0, wr_en_i, rd_en_i, rvalid_o;
  logic amb_sel_ir_i = 0, amb_valid_i = 0, prox_valid_i = 0, amb_event_o, prox_event_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [15:0] visible_light_result_i = 0, infrared_light_result_i = 0, proximity_channel_one_i = 0;
  logic [3:0] emitter_one_drive_code_o, emitter_two_drive_code_o, emitter_three_drive_code_o;
  int err_total = 0, comparisons = 0;
  logic [23:0] rows [5] = '{24'h0E_A5A5, 24'h0F_2121, 24'h10_FF0F, 24'h11_5A5A, 24'h30_7700};
  always #50 mclk_i = ~mclk_i;
  threshold_led_drive_regs u_threshold_led_drive_regs (.*);
  host_model u_host_model (.mclk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ev(input logic p, input logic s, input logic [15:0] v, input logic x);
    @(posedge mclk_i);
    amb_sel_ir_i <= s;
    visible_light_result_i <= s ? ~v : v;
    infrared_light_result_i <= s ? v : ~v;
    proximity_channel_one_i <= v;
    prox_valid_i <= p;
    amb_valid_i <= !p;
    @(posedge mclk_i);
    prox_valid_i <= 1'b0;
    amb_valid_i <= 1'b0;
    #1 chk({7'h00, p ? prox_event_o : amb_event_o}, {7'h00, x});
  endtask
  initial begin
    #1ms;
    err_total++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      u_host_model.xfer(1'b0, rows[i][23:16], 8'h00);
      #1 chk(rdata_o, 8'h00);
      u_host_model.xfer(1'b1, rows[i][23:16], rows[i][15:8]);
      u_host_model.xfer(1'b0, rows[i][23:16], 8'h00);
      #1 chk(rdata_o, rows[i][7:0]);
      chk({7'h00, rvalid_o}, 8'h01);
    end
    chk({emitter_two_drive_code_o, emitter_one_drive_code_o}, 8'h21);
    chk({4'h0, emitter_three_drive_code_o}, 8'h0F);
    u_host_model.xfer(1'b1, 8'h11, 8'h10);
    ev(1'b1, 1'b0, 16'h0011, 1'b1);
    ev(1'b1, 1'b0, 16'h0010, 1'b0);
    u_host_model.xfer(1'b1, 8'h12, 8'h01);
    ev(1'b1, 1'b0, 16'h0111, 1'b1);
    ev(1'b1, 1'b0, 16'h0110, 1'b0);
    u_host_model.xfer(1'b1, 8'h0B, 8'h10);
    u_host_model.xfer(1'b1, 8'h0E, 8'h01);
    ev(1'b0, 1'b0, 16'h000F, 1'b1);
    ev(1'b0, 1'b1, 16'h0101, 1'b1);
    ev(1'b0, 1'b0, 16'h0050, 1'b0);
    ev(1'b0, 1'b1, 16'h0100, 1'b0);
    // Legacy silicon: limits expand from one compressed byte
    @(posedge mclk_i);
    legacy_rev_i <= 1'b1;
    u_host_model.xfer(1'b1, 8'h11, 8'h53);
    ev(1'b1, 1'b0, 16'h0027, 1'b1);
    ev(1'b1, 1'b0, 16'h0026, 1'b0);
    u_host_model.xfer(1'b1, 8'h0D, 8'h62);
    ev(1'b0, 1'b0, 16'h0049, 1'b1);
    ev(1'b0, 1'b0, 16'h0048, 1'b0);
    @(posedge mclk_i);
    legacy_rev_i <= 1'b0;
    // Reset in mid-run clears every register
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    #1 chk({emitter_two_drive_code_o, emitter_one_drive_code_o}, 8'h00);
    chk({4'h0, emitter_three_drive_code_o}, 8'h00);
    u_host_model.xfer(1'b0, 8'h0E, 8'h00);
    #1 chk(rdata_o, 8'h00);
    complete_run;
  end
endmodule // tb_threshold_led_drive_regs

// ===== threshold_led_drive_regs.v
// Purpose: Limit and emitter-drive registers with window and limit comparators
// Assumes: Host byte writes/reads arrive already decoded from the two-wire bus
// Notes:   Results come from logic on the same clock; no resynchronisation
`include "threshold_led_drive_regs.vh"

module threshold_led_drive_regs (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire        legacy_rev_i,
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wdata_i,
  output reg  [7:0]  rdata_o,
  output reg         rvalid_o,
  input  wire        amb_sel_ir_i,
  input  wire [15:0] visible_light_result_i,
  input  wire [15:0] infrared_light_result_i,
  input  wire        amb_valid_i,
  input  wire [15:0] proximity_channel_one_i,
  input  wire        prox_valid_i,
  output reg         amb_event_o,
  output reg         prox_event_o,
  output wire [3:0]  emitter_one_drive_code_o,
  output wire [3:0]  emitter_two_drive_code_o,
  output wire [3:0]  emitter_three_drive_code_o
);

  reg [7:0] amb_low_lo_reg;
  reg [7:0] amb_low_hi_reg;
  reg [7:0] amb_up_lo_reg;
  reg [7:0] ambient_upper_limit_high_reg;
  reg [7:0] emitter_one_two_drive_reg;
  reg [7:0] emitter_three_drive_reg;
  reg [7:0] prox_one_limit_low_reg;
  reg [7:0] prox_one_limit_high_reg;

  reg [7:0]  rdata_next;
  wire [15:0] amb_result;
  wire [15:0] amb_lower_limit;
  wire [15:0] amb_upper_limit;
  wire [15:0] prox_one_limit;

  // Legacy compressed byte: exponent in upper nibble, mantissa in lower
  function [15:0] expand;
    input [7:0] c;
    reg   [4:0] m;
    begin
      m = {1'b1, c[3:0]};
      if (c[7:4] == 4'h0) begin
        expand = 16'h0000;
      end else if (c[7:4] >= 4'h4) begin
        expand = ({11'h000, m} << (c[7:4] - 4'h4)) | 16'h0000;
      end else begin
        expand = {11'h000, m} >> (4'h4 - c[7:4]);
      end
    end
  endfunction

  // Each byte updates alone; no shadow, so a half-written limit is live
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      amb_low_lo_reg               <= `LIMIT_RESET;
      amb_low_hi_reg               <= `LIMIT_RESET;
      amb_up_lo_reg                <= `LIMIT_RESET;
      ambient_upper_limit_high_reg <= `LIMIT_RESET;
      emitter_one_two_drive_reg    <= `DRIVE_RESET;
      emitter_three_drive_reg      <= `DRIVE_RESET;
      prox_one_limit_low_reg       <= `LIMIT_RESET;
      prox_one_limit_high_reg      <= `LIMIT_RESET;
    end else if (wr_en_i) begin
      case (addr_i)
        `AMB_LOW_LIMIT_LOW_ADDR:   amb_low_lo_reg <= wdata_i;
        `AMB_LOW_LIMIT_HIGH_ADDR:  amb_low_hi_reg <= wdata_i;
        `AMB_UP_LIMIT_LOW_ADDR:    amb_up_lo_reg <= wdata_i;
        `AMB_UP_LIMIT_HIGH_ADDR:   ambient_upper_limit_high_reg <= wdata_i;
        `EMITTER_ONE_TWO_ADDR:     emitter_one_two_drive_reg <= wdata_i;
        `EMITTER_THREE_ADDR:       emitter_three_drive_reg <= wdata_i & `EMIT_RSVD_MASK;
        `PROX_ONE_LIMIT_LOW_ADDR:  prox_one_limit_low_reg <= wdata_i;
        `PROX_ONE_LIMIT_HIGH_ADDR: prox_one_limit_high_reg <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (addr_i)
      `AMB_LOW_LIMIT_LOW_ADDR:   rdata_next = amb_low_lo_reg;
      `AMB_LOW_LIMIT_HIGH_ADDR:  rdata_next = amb_low_hi_reg;
      `AMB_UP_LIMIT_LOW_ADDR:    rdata_next = amb_up_lo_reg;
      `AMB_UP_LIMIT_HIGH_ADDR:   rdata_next = ambient_upper_limit_high_reg;
      `EMITTER_ONE_TWO_ADDR:     rdata_next = emitter_one_two_drive_reg;
      `EMITTER_THREE_ADDR:       rdata_next = emitter_three_drive_reg;
      `PROX_ONE_LIMIT_LOW_ADDR:  rdata_next = prox_one_limit_low_reg;
      `PROX_ONE_LIMIT_HIGH_ADDR: rdata_next = prox_one_limit_high_reg;
      default:                   rdata_next = 8'h00;
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= rdata_next;
      end
    end
  end

  // Drive codes go straight to the emitter drivers; 0 is off, 1..15 rising
  assign emitter_one_drive_code_o   = emitter_one_two_drive_reg[`EMIT_ONE_MSB:`EMIT_ONE_LSB];
  assign emitter_two_drive_code_o   = emitter_one_two_drive_reg[`EMIT_TWO_MSB:`EMIT_TWO_LSB];
  assign emitter_three_drive_code_o =
    emitter_three_drive_reg[`EMIT_THREE_MSB:`EMIT_THREE_LSB];

  // Low address is the low byte; legacy parts use one compressed byte
  assign amb_lower_limit = legacy_rev_i ? expand(amb_low_lo_reg)
                                        : {amb_low_hi_reg, amb_low_lo_reg};
  assign amb_upper_limit = legacy_rev_i ? expand(amb_up_lo_reg)
                                        : {ambient_upper_limit_high_reg, amb_up_lo_reg};
  assign prox_one_limit  = legacy_rev_i ? expand(prox_one_limit_low_reg)
                                        : {prox_one_limit_high_reg, prox_one_limit_low_reg};
  assign amb_result = amb_sel_ir_i ? infrared_light_result_i : visible_light_result_i;

  // Event pulses one cycle after a valid result crosses its limit
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      amb_event_o  <= 1'b0;
      prox_event_o <= 1'b0;
    end else begin
      amb_event_o  <= amb_valid_i &&
                      ((amb_result < amb_lower_limit) || (amb_result > amb_upper_limit));
      prox_event_o <= prox_valid_i && (proximity_channel_one_i > prox_one_limit);
    end
  end

endmodule // threshold_led_drive_regs

// ===== threshold_led_drive_regs.vh
// Purpose: Register offsets, field positions and reset values for the limit/drive bank
// Assumes: Byte-wide registers at their printed offsets
// Notes:   Guarded against double inclusion
`ifndef THRESHOLD_LED_DRIVE_REGS_VH
`define THRESHOLD_LED_DRIVE_REGS_VH

`define AMB_LOW_LIMIT_LOW_ADDR   8'h0B
`define AMB_LOW_LIMIT_HIGH_ADDR  8'h0C
`define AMB_UP_LIMIT_LOW_ADDR    8'h0D
`define AMB_UP_LIMIT_HIGH_ADDR   8'h0E
`define EMITTER_ONE_TWO_ADDR     8'h0F
`define EMITTER_THREE_ADDR       8'h10
`define PROX_ONE_LIMIT_LOW_ADDR  8'h11
`define PROX_ONE_LIMIT_HIGH_ADDR 8'h12

`define EMIT_ONE_MSB   3
`define EMIT_ONE_LSB   0
`define EMIT_TWO_MSB   7
`define EMIT_TWO_LSB   4
`define EMIT_THREE_MSB 3
`define EMIT_THREE_LSB 0

`define LIMIT_RESET    8'h00
`define DRIVE_RESET    8'h00
`define EMIT_RSVD_MASK 8'h0F

`endif

// ===== threshold_led_drive_regs_checker.sv
// Purpose: Port assertions for the limit and drive bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every bank instance
module threshold_led_drive_regs_checker (
  input wire logic       mclk_i, rst_n_i, wr_en_i, rd_en_i, rvalid_o,
  input wire logic       amb_valid_i, prox_valid_i, amb_event_o, prox_event_o,
  input wire logic [7:0] addr_i, wdata_i,
  input wire logic [3:0] emitter_one_drive_code_o, emitter_two_drive_code_o,
  input wire logic [3:0] emitter_three_drive_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wd_q;
  wire        w0f = wr_en_i && addr_i == 8'h0F;
  wire        w10 = wr_en_i && addr_i == 8'h10;
  always @(posedge mclk_i) wd_q <= wdata_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RD: assert property (rd_en_i |=> rvalid_o) else $error("read lost");
  AST_NORD: assert property (!rd_en_i |=> !rvalid_o) else $error("stray rvalid");
  AST_PEV: assert property (!prox_valid_i |=> !prox_event_o) else $error("stray prox");
  AST_AEV: assert property (!amb_valid_i |=> !amb_event_o) else $error("stray amb");
  AST_E1: assert property (w0f |=> emitter_one_drive_code_o == wd_q[3:0]) else $error("e1");
  AST_E2: assert property (w0f |=> emitter_two_drive_code_o == wd_q[7:4]) else $error("e2");
  AST_E3: assert property (w10 |=> emitter_three_drive_code_o == wd_q[3:0]) else $error("e3");
  AST_HOLD: assert property (!wr_en_i |=>
    $stable({emitter_one_drive_code_o, emitter_two_drive_code_o, emitter_three_drive_code_o}))
    else $error("drift");
endmodule // threshold_led_drive_regs_checker

bind threshold_led_drive_regs threshold_led_drive_regs_checker u_chk (.*);
